//--- pwr_pkg.sv
// constants, modes and decode shared by the reset/sleep block
package pwr_pkg;
    // register addresses as seen on the register port
    localparam logic [7:0] ADDR_PWRCTL = 8'h87;
    localparam logic [7:0] ADDR_KEY = 8'h8e;
    localparam logic [7:0] ADDR_RSTWD = 8'hb1;
    // field positions
    localparam int BIT_WATCHDOG_OVERFLOW_FLAG = 7;
    localparam int BIT_POWERON_RESET_FLAG = 5;
    localparam int BIT_LOWVOLT_RESET_FLAG = 4;
    localparam int BIT_PINF = 3;
    localparam int WSEL_LSB = 0;
    localparam int BIT_IDL = 0;
    localparam int BIT_PD = 1;
    // unlock value for the suspend key
    localparam logic [7:0] KEY_VALUE = 8'h55;
    // reset values
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam logic [2:0] WSEL_RST = 3'h0;
    // asynchronous input slots
    localparam int IN_PIN = 0;
    localparam int IN_LVR = 1;
    localparam int IN_X0 = 2;
    localparam int IN_X1 = 3;
    localparam int IN_X4 = 4;
    localparam int N_ASYNC = 5;
    localparam logic [4:0] SYNC_IDLE = 5'h01;
    // timing
    localparam int CLK_HZ = 125000000;
    localparam int WDT_UNIT_MS = 1;
    localparam int WDT_UNIT_CYCLES = CLK_HZ / 1000 * WDT_UNIT_MS;
    localparam int WARMUP_DEFAULT = 2048;
    localparam int RST_HOLD_CYCLES = 16;
    // operating modes
    typedef enum logic [2:0] {M_RUN, M_LIGHT, M_DEEP, M_WARM, M_RESET} mode_t;
    // watchdog period select to least period in ms
    function automatic logic [12:0] wdt_period_ms(input logic [2:0] sel);
        case (sel)
            3'h0: wdt_period_ms = 13'h1000;
            3'h1: wdt_period_ms = 13'h0400;
            3'h2: wdt_period_ms = 13'h0100;
            3'h3: wdt_period_ms = 13'h0080;
            3'h4: wdt_period_ms = 13'h0040;
            3'h5: wdt_period_ms = 13'h0010;
            3'h6: wdt_period_ms = 13'h0004;
            default: wdt_period_ms = 13'h0001;
        endcase
    endfunction : wdt_period_ms
endpackage : pwr_pkg

//--- wdt_if.sv
// link between the sequencer and the watchdog down-counter
`timescale 1ns/1ps
interface wdt_if;
    logic restart;  // reload the count
    logic enable;   // watchdog allowed at all
    logic run;      // count this cycle
    logic [2:0] sel;  // period select
    logic overflow; // one-cycle overflow pulse
    modport ctrl(output restart, enable, run, sel, input overflow);
    modport counter(input restart, enable, run, sel, output overflow);
endinterface : wdt_if

//--- wdt_down_counter.sv
// watchdog down-counter with selectable period
`timescale 1ns/1ps
module wdt_down_counter #(
    parameter int MS_CYCLES = pwr_pkg::WDT_UNIT_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    wdt_if.counter wd
);
    typedef struct packed {
        logic [31:0] cnt;  // cycles left
        logic ovf;         // overflow pulse
    } wst_t;
    wst_t q;
    wst_t n;
    logic [31:0] load;  // reload value for the period

    // period in cycles from the select field
    assign load = 32'(pwr_pkg::wdt_period_ms(wd.sel)) * 32'(MS_CYCLES);

    // count down, reload on restart or when disabled
    always_comb begin
        n = q;
        n.ovf = 1'b0;
        if (!wd.enable || wd.restart) begin
            n.cnt = load - 32'h1;
        end else if (wd.run) begin
            if (q.cnt == 32'h0) begin
                n.ovf = 1'b1;
                n.cnt = load - 32'h1;
            end else begin
                n.cnt = q.cnt - 32'h1;
            end
        end
    end

    // state register
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '{cnt: 32'hffffffff, ovf: 1'b0};
        end else begin
            q <= n;
        end
    end

    assign wd.overflow = q.ovf;

    ovf_needs_en_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        wd.overflow |-> $past(wd.enable))
        else $error("watchdog overflow while disabled");
endmodule : wdt_down_counter

//--- reset_flags_and_sleep_control.sv
// reset-cause flags, watchdog control and light/deep sleep sequencing
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
module reset_flags_and_sleep_control #(
    parameter int WDT_MS_CYCLES = pwr_pkg::WDT_UNIT_CYCLES,
    parameter int WARMUP_CYCLES = pwr_pkg::WARMUP_DEFAULT
) (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_insn_retire,
    input wire logic i_code_range_fault,
    input wire logic i_rst_pin_n,
    input wire logic i_lowvolt,
    input wire logic i_lvr_enable,
    input wire logic i_wdt_enable,
    input wire logic i_wdt_pd_enable,
    input wire logic i_irq_pending,
    input wire logic i_ext_irq_zero,
    input wire logic i_ext_irq_one,
    input wire logic i_ext_irq_four,
    input wire logic i_timer3_irq,
    input wire logic i_timer3_slow_src,
    output logic o_cpu_clk_en,
    output logic o_periph_clk_en,
    output logic o_osc_en,
    output logic o_sys_reset
);
    // all state of the block
    typedef struct packed {
        logic [4:0] s1, s2, s3; // synchroniser stages one to three
        logic [4:0] stab;     // accepted input levels
        logic [7:0] rdata;    // read data, one cycle
        logic watchdog_overflow_flag, poweron_reset_flag, lowvolt_reset_flag, pinf; // overflow, power-on, low-voltage and pin flags
        logic [2:0] wsel;     // watchdog period select
        logic [7:0] key;      // suspend key
        logic [1:0] keyage;   // retired instructions since key write
        logic light_sleep_request, pd;        // light and deep sleep requests
        pwr_pkg::mode_t mode; // operating mode
        logic [31:0] cnt;     // warm-up or reset hold count
        logic rst_pend;       // reset waits for warm-up
        logic restart;        // watchdog reload pulse
        logic cpu_en, per_en, osc_en; // cpu, peripheral and oscillator enables
        logic sysrst;         // device reset
    } st_t;

    // power-on state: only the power-on flag is set
    localparam st_t ST_RST = '{
        s1: pwr_pkg::SYNC_IDLE, s2: pwr_pkg::SYNC_IDLE, s3: pwr_pkg::SYNC_IDLE,
        stab: pwr_pkg::SYNC_IDLE, poweron_reset_flag: 1'b1, restart: 1'b1, mode: pwr_pkg::M_RUN,
        cpu_en: 1'b1, per_en: 1'b1, osc_en: 1'b1, key: pwr_pkg::KEY_RST,
        wsel: pwr_pkg::WSEL_RST, default: '0
    };

    st_t q;
    st_t n;

    wdt_if wd();

    // decoded register accesses
    wire logic wr_rst = i_wr && (i_addr == pwr_pkg::ADDR_RSTWD); // reset/watchdog write
    wire logic rd_rst = i_rd && (i_addr == pwr_pkg::ADDR_RSTWD); // reset/watchdog read
    wire logic wr_key = i_wr && (i_addr == pwr_pkg::ADDR_KEY); // suspend key write
    wire logic wr_pc = i_wr && (i_addr == pwr_pkg::ADDR_PWRCTL); // power control write
    // reset events: pin held low, enabled low voltage, watchdog or code fault
    wire logic pin_ev = !q.stab[pwr_pkg::IN_PIN];
    wire logic lvr_ev = q.stab[pwr_pkg::IN_LVR] && i_lvr_enable;
    wire logic wdt_ev = wd.overflow || i_code_range_fault;
    wire logic rst_req = pin_ev || lvr_ev || wdt_ev; // any reset source
    logic go_rst; // enter reset hold this cycle
    // deep wake: external lines 0, 1, 4, or timer three on a slow source
    wire logic wake_dp = q.stab[pwr_pkg::IN_X0] || q.stab[pwr_pkg::IN_X1]
        || q.stab[pwr_pkg::IN_X4]
        || (i_timer3_irq && i_timer3_slow_src);
    // valid sleep request: key is the unlock value and at most one retire old
    wire logic sleep_go = wr_pc && (q.mode == pwr_pkg::M_RUN) && !rst_req
        && (i_wdata[pwr_pkg::BIT_IDL] || i_wdata[pwr_pkg::BIT_PD])
        && (q.key == pwr_pkg::KEY_VALUE) && (q.keyage != 2'h2);
    // watchdog control
    assign wd.restart = q.restart;
    assign wd.enable = i_wdt_enable;
    assign wd.sel = q.wsel;
    // in deep sleep the watchdog runs only if allowed there
    assign wd.run = !((q.mode == pwr_pkg::M_DEEP) && !i_wdt_pd_enable);

    wdt_down_counter #(.MS_CYCLES(WDT_MS_CYCLES)) u_wdt (
        .i_mclk(i_mclk),
        .i_reset_n(i_reset_n),
        .wd(wd.counter)
    );

    // next-state logic
    always_comb begin
        n = q;
        go_rst = 1'b0;
        n.rdata = 8'h00;
        n.restart = 1'b0;
        // three-stage synchronisers, level accepted when two and three agree
        n.s1 = {i_ext_irq_four, i_ext_irq_one, i_ext_irq_zero, i_lowvolt, i_rst_pin_n};
        n.s2 = q.s1;
        n.s3 = q.s2;
        for (int k = 0; k < pwr_pkg::N_ASYNC; k++) begin
            if (q.s2[k] == q.s3[k]) begin
                n.stab[k] = q.s3[k];
            end
        end

        // software writes
        if (wr_rst) begin
            n.watchdog_overflow_flag = i_wdata[pwr_pkg::BIT_WATCHDOG_OVERFLOW_FLAG];
            n.poweron_reset_flag = i_wdata[pwr_pkg::BIT_POWERON_RESET_FLAG];
            n.lowvolt_reset_flag = i_wdata[pwr_pkg::BIT_LOWVOLT_RESET_FLAG];
            n.pinf = i_wdata[pwr_pkg::BIT_PINF];
            n.wsel = i_wdata[pwr_pkg::WSEL_LSB +: 3];
        end
        // any access to the status register reloads the watchdog
        if (wr_rst || rd_rst) begin
            n.restart = 1'b1;
        end
        // key write restarts its age count
        if (wr_key) begin
            n.key = i_wdata;
            n.keyage = {1'b0, i_insn_retire};
        end else if (i_insn_retire && (q.keyage != 2'h2)) begin
            n.keyage = q.keyage + 2'h1;
        end
        if (wr_pc) begin
            n.light_sleep_request = i_wdata[pwr_pkg::BIT_IDL];
            n.pd = i_wdata[pwr_pkg::BIT_PD];
        end

        // stale key is dropped the cycle after the window closes
        if ((q.mode == pwr_pkg::M_RUN) && (q.keyage == 2'h2)
            && (q.key != pwr_pkg::KEY_RST) && !wr_key) begin
            n.key = pwr_pkg::KEY_RST;
        end
        // request bit without a valid key is dropped next cycle
        if ((q.mode == pwr_pkg::M_RUN) && (q.light_sleep_request || q.pd) && !wr_pc) begin
            n.light_sleep_request = 1'b0;
            n.pd = 1'b0;
        end

        // mode sequencing
        case (q.mode)
            pwr_pkg::M_RUN: begin
                if (rst_req) begin
                    go_rst = 1'b1;
                end else if (sleep_go) begin
                    // clocks stop right after the request write
                    n.cpu_en = 1'b0;
                    if (i_wdata[pwr_pkg::BIT_PD]) begin
                        n.mode = pwr_pkg::M_DEEP;
                        n.per_en = 1'b0;
                        n.osc_en = 1'b0;
                    end else begin
                        n.mode = pwr_pkg::M_LIGHT;
                    end
                end
            end
            pwr_pkg::M_LIGHT: begin
                // cpu frozen, peripherals still clocked
                if (rst_req) begin
                    go_rst = 1'b1;
                end else if (i_irq_pending) begin
                    n.mode = pwr_pkg::M_RUN;
                    n.cpu_en = 1'b1;
                    n.key = pwr_pkg::KEY_RST;
                    n.light_sleep_request = 1'b0;
                    n.pd = 1'b0;
                end
            end
            pwr_pkg::M_DEEP: begin
                // all clocks stopped, oscillator off
                if (rst_req || wake_dp) begin
                    n.mode = pwr_pkg::M_WARM;
                    n.rst_pend = rst_req;
                    n.osc_en = 1'b1;
                    n.cnt = 32'(WARMUP_CYCLES - 1);
                end
            end
            pwr_pkg::M_WARM: begin
                // oscillator settles before clocks return
                if (rst_req) begin
                    n.rst_pend = 1'b1;
                end
                if (q.cnt == 32'h0) begin
                    // both requests cleared, no fall into light sleep
                    n.key = pwr_pkg::KEY_RST;
                    n.light_sleep_request = 1'b0;
                    n.pd = 1'b0;
                    n.rst_pend = 1'b0;
                    if (q.rst_pend || rst_req) begin
                        go_rst = 1'b1;
                    end else begin
                        n.mode = pwr_pkg::M_RUN;
                        n.cpu_en = 1'b1;
                        n.per_en = 1'b1;
                    end
                end else begin
                    n.cnt = q.cnt - 32'h1;
                end
            end
            pwr_pkg::M_RESET: begin
                // hold device reset, release once sources are gone
                n.restart = 1'b1;
                if (q.cnt != 32'h0) begin
                    n.cnt = q.cnt - 32'h1;
                end else if (rst_req) begin
                    go_rst = 1'b1;
                end else begin
                    n.mode = pwr_pkg::M_RUN;
                    n.sysrst = 1'b0;
                end
            end
            default: begin
                n.mode = pwr_pkg::M_RUN;
            end
        endcase

        // entering reset: clocks back, sleep state and period cleared
        if (go_rst) begin
            n.mode = pwr_pkg::M_RESET;
            n.cnt = 32'(pwr_pkg::RST_HOLD_CYCLES - 1);
            n.sysrst = 1'b1;
            n.cpu_en = 1'b1;
            n.per_en = 1'b1;
            n.osc_en = 1'b1;
            n.key = pwr_pkg::KEY_RST;
            n.keyage = 2'h0;
            n.light_sleep_request = 1'b0;
            n.pd = 1'b0;
            n.wsel = pwr_pkg::WSEL_RST;
        end

        // hardware sets win over a software clear
        if (wdt_ev) begin
            n.watchdog_overflow_flag = 1'b1;
        end
        if (lvr_ev) begin
            n.lowvolt_reset_flag = 1'b1;
        end
        if (pin_ev) begin
            n.pinf = 1'b1;
        end

        // read data for one cycle after the strobe, zero otherwise
        if (rd_rst) begin
            n.rdata = {q.watchdog_overflow_flag, 1'b0, q.poweron_reset_flag, q.lowvolt_reset_flag, q.pinf, q.wsel};
        end else if (i_rd && (i_addr == pwr_pkg::ADDR_KEY)) begin
            n.rdata = q.key;
        end else if (i_rd && (i_addr == pwr_pkg::ADDR_PWRCTL)) begin
            n.rdata = {6'h00, q.pd, q.light_sleep_request};
        end
    end

    // state register, power-on reset only
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= ST_RST;
        end else begin
            q <= n;
        end
    end

    assign o_rdata = q.rdata;
    assign o_cpu_clk_en = q.cpu_en;
    assign o_periph_clk_en = q.per_en;
    assign o_osc_en = q.osc_en;
    assign o_sys_reset = q.sysrst;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_reset_n);

    watchdog_overflow_flag_set_a: assert property (wdt_ev |=> q.watchdog_overflow_flag)
        else $error("overflow flag not set");
    poweron_reset_flag_keep_a: assert property (q.poweron_reset_flag && !wr_rst |=> q.poweron_reset_flag)
        else $error("power-on flag lost without write");
    lowvolt_reset_flag_set_a: assert property (lvr_ev |=> q.lowvolt_reset_flag)
        else $error("low-voltage flag not set");
    pinf_set_a: assert property ($fell(q.stab[pwr_pkg::IN_PIN]) |=> q.pinf ##1 q.pinf)
        else $error("pin flag not set");
    light_clk_a: assert property (q.mode == pwr_pkg::M_LIGHT |->
        !o_cpu_clk_en && o_periph_clk_en)
        else $error("light sleep clocks wrong");
    bad_seq_a: assert property ((q.mode == pwr_pkg::M_RUN) && (q.light_sleep_request || q.pd)
        && !wr_pc |=> !q.light_sleep_request && !q.pd)
        else $error("stray sleep request not cleared");
    deep_pick_a: assert property (sleep_go && i_wdata[pwr_pkg::BIT_PD] |=>
        (q.mode == pwr_pkg::M_DEEP) && !o_cpu_clk_en && !o_periph_clk_en)
        else $error("deep sleep not entered");
    light_wake_a: assert property ((q.mode == pwr_pkg::M_LIGHT) && i_irq_pending
        && !rst_req |=> (q.mode == pwr_pkg::M_RUN) && o_cpu_clk_en
        && (q.key == pwr_pkg::KEY_RST) && !q.light_sleep_request)
        else $error("light sleep wake wrong");
    deep_wake_a: assert property ((q.mode == pwr_pkg::M_DEEP) && wake_dp |=>
        (q.mode == pwr_pkg::M_WARM) && o_osc_en && !o_cpu_clk_en)
        else $error("deep wake did not start warm-up");
    wdt_kick_a: assert property (rd_rst |=> wd.restart)
        else $error("status read did not restart watchdog");
    light_rst_a: assert property ((q.mode == pwr_pkg::M_LIGHT) && rst_req |=>
        o_sys_reset && o_cpu_clk_en && (q.key == pwr_pkg::KEY_RST))
        else $error("reset in light sleep wrong");

    light_cycle_c: cover property ((q.mode == pwr_pkg::M_LIGHT) ##1 (q.mode == pwr_pkg::M_RUN));
    deep_cycle_c: cover property ((q.mode == pwr_pkg::M_WARM) ##1 (q.mode == pwr_pkg::M_RUN));
    wdt_reset_c: cover property (wd.overflow ##1 o_sys_reset);
endmodule : reset_flags_and_sleep_control

//--- cpu_model.sv
// behavioural cpu core: retires one instruction per issued cycle while clocked
`timescale 1ns/1ps
module cpu_model (
    input wire logic i_issue,
    input wire logic i_cpu_clk_en,
    output logic o_retire
);
    // a halted core retires nothing, so the sleep request is its last instruction
    // the bench issues key and request back to back or with one stray instruction between, then three no-ops
    assign o_retire = i_issue & i_cpu_clk_en;
endmodule : cpu_model

//--- tb_top.sv
// self-checking bench for the reset-cause flags and sleep sequencer
`timescale 1ns/1ps
module tb_top;
    localparam int WARM = 16;  // shortened oscillator warm-up
    localparam int MSC = 4;  // cycles per watchdog millisecond
    localparam logic [7:0] AK = pwr_pkg::ADDR_KEY;
    localparam logic [7:0] AP = pwr_pkg::ADDR_PWRCTL;
    localparam logic [7:0] AR = pwr_pkg::ADDR_RSTWD;
    logic i_mclk, i_reset_n, i_wr, i_rd, issue, retire;
    logic [7:0] i_addr, i_wdata, o_rdata, q, k;
    logic i_code_range_fault, i_rst_pin_n, i_lowvolt, i_lvr_enable, i_wdt_enable;
    logic i_wdt_pd_enable, i_irq_pending, i_ext_irq_zero, i_ext_irq_one, i_ext_irq_four;
    logic i_timer3_irq, i_timer3_slow_src;
    logic o_cpu_clk_en, o_periph_clk_en, o_osc_en, o_sys_reset;
    int n, n_fail, checks;
    // device under test with short counts
    reset_flags_and_sleep_control #(.WDT_MS_CYCLES(MSC), .WARMUP_CYCLES(WARM))
    reset_flags_and_sleep_control_i (
        .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_insn_retire(retire),
        .i_code_range_fault(i_code_range_fault), .i_rst_pin_n(i_rst_pin_n),
        .i_lowvolt(i_lowvolt), .i_lvr_enable(i_lvr_enable), .i_wdt_enable(i_wdt_enable),
        .i_wdt_pd_enable(i_wdt_pd_enable), .i_irq_pending(i_irq_pending),
        .i_ext_irq_zero(i_ext_irq_zero), .i_ext_irq_one(i_ext_irq_one),
        .i_ext_irq_four(i_ext_irq_four), .i_timer3_irq(i_timer3_irq),
        .i_timer3_slow_src(i_timer3_slow_src), .o_cpu_clk_en(o_cpu_clk_en),
        .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en), .o_sys_reset(o_sys_reset)
    );
    // core model turning issued cycles into retire pulses
    cpu_model cpu_model_i (.i_issue(issue), .i_cpu_clk_en(o_cpu_clk_en), .o_retire(retire));
    // free-running clock
    initial begin
        i_mclk = 1'h0;
        forever #4 i_mclk = ~i_mclk;
    end
    // verdict and end of run
    task automatic finish_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // register value comparison
    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp8
    // single flag comparison
    task automatic cmp1(input string nm, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp1
    // one bus cycle: every bus input assigned once per edge
    task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                       input logic s);
        @(posedge i_mclk);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        issue <= s;
    endtask : cyc
    task automatic idle(input int c);
        repeat (c) cyc(1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cyc(1'h1, 1'h0, a, d, 1'h1);
    endtask : wr
    // read strobe, then take data in the following cycle only
    task automatic chk(input logic [7:0] a, input logic [7:0] e, input string nm);
        cyc(1'h0, 1'h1, a, 8'h00, 1'h1);
        cyc(1'h0, 1'h0, 8'h00, 8'h00, 1'h0);
        #1 q = o_rdata;
        cmp8(nm, e, q);
    endtask : chk
    function automatic logic sig(input int s);
        return (s == 0) ? o_cpu_clk_en : (s == 1) ? o_sys_reset : o_periph_clk_en;
    endfunction : sig
    // bounded wait for an output level, n counts cycles
    task automatic wait_for(input int s, input logic v, input int lim);
        n = 0;
        forever begin
            #1;
            if (sig(s) === v || n >= lim) break;
            idle(1);
            n++;
        end
    endtask : wait_for
    // key then request, optionally with a stray instruction between, then three no-ops
    task automatic enter(input logic [7:0] v, input logic good);
        wr(AK, pwr_pkg::KEY_VALUE);
        if (!good) cyc(1'h0, 1'h0, 8'h00, 8'h00, 1'h1);
        wr(AP, v);
        repeat (3) cyc(1'h0, 1'h0, 8'h00, 8'h00, 1'h1);
        #1;
    endtask : enter
    // power-on values and an unmapped address
    task automatic t_reset;
        chk(AR, 8'h20, "rst_after_por");
        chk(AK, 8'h00, "key_after_por");
        chk(AP, 8'h00, "pwr_after_por");
        chk(8'h10, 8'h00, "unmapped");
        wr(AR, 8'h07);
        chk(AR, 8'h07, "sw_clear_sel");
    endtask : t_reset
    // each reset source sets only its own flag
    task automatic t_flags;
        for (int j = 0; j < 3; j++) begin
            wr(AR, 8'h00);
            idle(2);
            if (j == 0) i_code_range_fault <= 1'h1;
            if (j == 1) i_lowvolt <= 1'h1;
            if (j == 2) i_rst_pin_n <= 1'h0;
            idle(1);
            i_code_range_fault <= 1'h0;
            wait_for(1, 1'h1, 10);
            i_lowvolt <= 1'h0;
            i_rst_pin_n <= 1'h1;
            wait_for(1, 1'h0, 60);
            chk(AR, (j == 0) ? 8'h80 : (j == 1) ? 8'h10 : 8'h08, "cause_flag");
        end
        // low voltage with its reset option off neither resets nor flags
        i_lvr_enable <= 1'h0;
        i_lowvolt <= 1'h1;
        wait_for(1, 1'h1, 8);
        cmp1("lvr_off", 1'h0, o_sys_reset);
        i_lowvolt <= 1'h0;
        idle(6);
        i_lvr_enable <= 1'h1;
        chk(AR, 8'h08, "lvr_off_flag");
    endtask : t_flags
    // watchdog kept alive by status reads, then left to bite
    task automatic t_wdt;
        wr(AR, 8'h06);
        i_wdt_enable <= 1'h1;
        repeat (6) begin
            idle(6);
            chk(AR, 8'h06, "wdt_sel");
        end
        cmp1("wdt_kept", 1'h0, o_sys_reset);
        wait_for(1, 1'h1, 40);
        cmp1("wdt_period", 1'h1, n >= 14 && n <= 20);
        i_wdt_enable <= 1'h0;
        wait_for(1, 1'h0, 60);
        cmp1("rst_hold", 1'h1, n >= pwr_pkg::RST_HOLD_CYCLES - 1);
        chk(AR, 8'h80, "wdt_flag");
    endtask : t_wdt
    // light sleep entry and interrupt exit
    task automatic t_light;
        enter(8'h01, 1'h1);
        cmp1("light_cpu", 1'h0, o_cpu_clk_en);
        cmp1("light_per", 1'h1, o_periph_clk_en);
        chk(AP, 8'h01, "light_bit");
        i_irq_pending <= 1'h1;
        wait_for(0, 1'h1, 5);
        i_irq_pending <= 1'h0;
        cmp1("light_wake", 1'h1, o_cpu_clk_en);
        chk(AK, 8'h00, "light_key");
        chk(AP, 8'h00, "light_clr");
    endtask : t_light
    // broken sequences for both modes are refused
    task automatic t_refuse;
        for (int j = 1; j < 3; j++) begin
            enter(8'(j), 1'h0);
            cmp1("refuse_cpu", 1'h1, o_cpu_clk_en && o_osc_en);
            chk(AK, 8'h00, "key_peek");
            k = q;
            chk(AP, 8'h00, "pwr_peek");
            cmp1("refuse_clr", 1'h1, k == 8'h00 || q[1:0] == 2'h0);
        end
    endtask : t_refuse
    // deep sleep woken by each external line and by the slow-clocked timer
    task automatic t_deep;
        for (int j = 0; j < 4; j++) begin
            enter((j == 0) ? 8'h03 : 8'h02, 1'h1);
            cmp1("deep_off", 1'h0, o_cpu_clk_en | o_periph_clk_en | o_osc_en);
            if (j == 3) begin
                i_timer3_irq <= 1'h1;
                idle(30);
                #1;
                cmp1("fast_timer", 1'h0, o_cpu_clk_en);
                i_timer3_slow_src <= 1'h1;
            end
            i_ext_irq_zero <= (j == 0);
            i_ext_irq_one <= (j == 1);
            i_ext_irq_four <= (j == 2);
            wait_for(0, 1'h1, 100);
            cmp1("warm_wake", 1'h1, n >= WARM && o_periph_clk_en);
            {i_ext_irq_zero, i_ext_irq_one, i_ext_irq_four, i_timer3_irq} <= 4'h0;
            i_timer3_slow_src <= 1'h0;
            idle(4);
            chk(AP, 8'h00, "deep_clr");
            chk(AK, 8'h00, "deep_key");
        end
    endtask : t_deep
    // pin reset while in light, then in deep sleep
    task automatic t_rst_sleep;
        for (int m = 0; m < 2; m++) begin
            enter((m == 0) ? 8'h01 : 8'h02, 1'h1);
            i_rst_pin_n <= 1'h0;
            wait_for(1, 1'h1, 100);
            cmp1("rst_delay", 1'h1, (m == 0) ? n <= 6 : n >= WARM);
            cmp1("rst_cpu", 1'h1, o_cpu_clk_en);
            i_rst_pin_n <= 1'h1;
            wait_for(1, 1'h0, 60);
            chk(AK, 8'h00, "rst_key");
            chk(AP, 8'h00, "rst_pwr");
        end
    endtask : t_rst_sleep
    // hang guard
    initial begin
        repeat (20000) @(posedge i_mclk);
        n_fail++;
        finish_test;
    end
    // main sequence
    initial begin
        {i_wr, i_rd, issue, i_code_range_fault, i_lowvolt, i_wdt_enable} = 6'h00;
        {i_wdt_pd_enable, i_irq_pending, i_timer3_irq, i_timer3_slow_src} = 4'h0;
        {i_ext_irq_zero, i_ext_irq_one, i_ext_irq_four} = 3'h0;
        i_addr = 8'h00;
        i_wdata = 8'h00;
        i_rst_pin_n = 1'h1;
        i_lvr_enable = 1'h1;
        n_fail = 0;
        checks = 0;
        i_reset_n = 1'h0;
        repeat (6) @(posedge i_mclk);
        i_reset_n <= 1'h1;
        t_reset;
        t_flags;
        t_wdt;
        t_light;
        t_refuse;
        t_deep;
        t_rst_sleep;
        finish_test;
    end
endmodule : tb_top
